// [rtl/bkc_pkg.sv]
package bkc_pkg;
  // register offsets, chosen for the serial register pointer
  localparam logic [7:0] OFS_CTRL_BASE = 8'h00;
  localparam logic [7:0] OFS_REF_BASE = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_PG_STATUS = 8'h0D;
  // control register fields
  localparam int CTRL_FAST_EDGE = 0;
  localparam int CTRL_KEEP_STBY = 1;
  localparam int CTRL_FREQ_LOW = 2;
  localparam int CTRL_PHASE2 = 3;
  localparam int CTRL_LOW_V_GATE = 4;
  localparam int CTRL_MODE_LSB = 5;
  localparam int CTRL_ENABLE = 7;
  // reference register fields
  localparam int REF_CODE_MSB = 4;
  localparam int REF_FLAG = 5;
  // reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [5:0] REF_RESET = 6'h19;
  // operating mode codes
  localparam logic [1:0] MODE_PULSE_SKIP = 2'h0;
  localparam logic [1:0] MODE_BURST = 2'h1;
  localparam logic [1:0] MODE_FORCED_CCM = 2'h2;
  // reference scale in microvolts
  localparam int UV_W = 20;
  localparam logic [UV_W-1:0] REF_BASE_UV = 20'h64B54;
  localparam logic [UV_W-1:0] REF_STEP_UV = 20'h030D4;
  // timing: rates as printed, per-cycle steps derived from the clock
  localparam int CLK_PERIOD_NS = 40;
  localparam int SLEW_UV_PER_US = 3500;
  localparam int SS_UV_PER_MS = 800000;
  localparam int SLEW_STEP_INT = SLEW_UV_PER_US * CLK_PERIOD_NS / 1000;
  localparam int SS_STEP_INT = SS_UV_PER_MS * CLK_PERIOD_NS / 1000000;
  localparam logic [UV_W-1:0] SLEW_STEP_UV = SLEW_STEP_INT[UV_W-1:0];
  localparam logic [UV_W-1:0] SS_STEP_UV = (SS_STEP_INT < 1) ? 20'h00001 : SS_STEP_INT[UV_W-1:0];
  // synchronised pin vector layout
  localparam int PIN_SCL = 0;
  localparam int PIN_SDA = 1;
  localparam int PIN_VSEL = 2;
  localparam int PIN_EN = 3;
  localparam int PIN_LOWV = 7;
  localparam int PIN_PG = 11;
  localparam int PIN_W = 15;
  // serial slave states
  typedef enum logic [6:0] {
    BKC_IDLE = 7'b0000001,
    BKC_ADDR = 7'b0000010,
    BKC_ACK_A = 7'b0000100,
    BKC_WR = 7'b0001000,
    BKC_ACK_W = 7'b0010000,
    BKC_RD = 7'b0100000,
    BKC_ACK_R = 7'b1000000
  } bkc_i2c_st_t;
endpackage

// [rtl/bkc_top.sv]
`timescale 1ns/1ps
// How it works
// RL1: enabled regulator ramps reference up at 0.8V/ms
// RL2: soft-start forces pulse-skipping mode
// RL3: bit0 picks normal or fast switch edge
// RL4: bit1 keeps regulator on in standby
// RL5: bit2 frequency select, inverted on regulator1 variant
// RL6: bit3 picks clock phase one or two
// RL7: bit4 gates enable to output below 300mV
// RL8: bits6:5 pick skip, burst or forced mode
// RL9: bit7 enables, else enable pin decides
// RL10: 5-bit code maps 412.5mV to 800mV linearly
// RL11: code change slews reference at 3.5mV/us
// RL12: two codes per regulator, A-register bit5 selects
// RL13: standby-voltage pin ORs into select on all
// RL14: host sets A equal B for no change
// RL15: B-register bit5 masks power-good during slew
// RL16: slew only pulls pin, status left alone
// RL17: reference codes reset to code 25
// RL18: entering standby clears enable bits, ignores pins
// RL19: mode code 11 runs pulse-skipping
// RL20: slew retargets to latest code at once
module bkc_top #(
  parameter logic [6:0] DEV_ADDR = 7'h3C, // arbitrary default
  parameter logic DDR_VARIANT = 1'b0
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // serial register port, open drain data
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oen,
  // device pins
  input wire logic reg1_enable_pin,
  input wire logic reg2_enable_pin,
  input wire logic reg3_enable_pin,
  input wire logic reg4_enable_pin,
  input wire logic standby_voltage_select_pin,
  // analog feedback
  input wire logic [3:0] out_below_300mv,
  input wire logic [3:0] pg_comparator_ok,
  // operating state from the sequencer
  input wire logic standby_state,
  // converter controls
  output logic [3:0] reg_on,
  output logic [3:0] fast_edge,
  output logic [3:0] sw_freq_low,
  output logic [3:0] phase2_sel,
  output logic [3:0][1:0] op_mode,
  output logic [3:0] soft_start_active,
  output logic [3:0][bkc_pkg::UV_W-1:0] ref_uv,
  // power-good pin, open drain
  output logic power_good_o,
  output logic power_good_oen
);

  logic [bkc_pkg::PIN_W-1:0] pin_raw;
  logic [bkc_pkg::PIN_W-1:0] sync1_r;
  logic [bkc_pkg::PIN_W-1:0] sync2_r;
  logic [bkc_pkg::PIN_W-1:0] sync3_r;
  logic [bkc_pkg::PIN_W-1:0] pin_f_r;
  logic scl_prev_r;
  logic sda_prev_r;
  logic [7:0] ctrl_r [4];
  logic [5:0] refa_r [4];
  logic [5:0] refb_r [4];
  logic [3:0] slewing;
  logic [3:0] ss_done_r;
  logic standby_prev_r;
  logic standby_entry;
  bkc_pkg::bkc_i2c_st_t st_r;
  logic [7:0] sh_r;
  logic [7:0] tx_r;
  logic [7:0] ptr_r;
  logic [2:0] cnt_r;
  logic done_r;
  logic first_r;
  logic rw_r;
  logic wr_stb_r;
  logic [7:0] wr_addr_r;
  logic [7:0] wr_data_r;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic sda_f;
  logic pg_pull_r;
  logic [7:0] rd_data;
  // serial lines idle high, so their sync stages start high to avoid a false edge
  localparam logic [bkc_pkg::PIN_W-1:0] PIN_IDLE = bkc_pkg::PIN_W'((1 << bkc_pkg::PIN_SCL) | (1 << bkc_pkg::PIN_SDA));

  assign pin_raw = {pg_comparator_ok, out_below_300mv, reg4_enable_pin, reg3_enable_pin,
                    reg2_enable_pin, reg1_enable_pin, standby_voltage_select_pin, sda_i, scl_i};

  // three-stage sync; the filter only looks at stages two and three
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sync1_r <= PIN_IDLE;
      sync2_r <= PIN_IDLE;
      sync3_r <= PIN_IDLE;
    end else begin
      sync1_r <= pin_raw;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // per-bit change accepted once two stages agree
  generate
    for (genvar p = 0; p < bkc_pkg::PIN_W; p++) begin : g_filt
      always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          pin_f_r[p] <= (p == bkc_pkg::PIN_SCL || p == bkc_pkg::PIN_SDA) ? 1'b1 : 1'b0;
        end else if (sync2_r[p] == sync3_r[p]) begin
          pin_f_r[p] <= sync3_r[p];
        end
      end
    end
  endgenerate

  // edge history of the serial lines
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      scl_prev_r <= 1'b1;
      sda_prev_r <= 1'b1;
    end else begin
      scl_prev_r <= pin_f_r[bkc_pkg::PIN_SCL];
      sda_prev_r <= pin_f_r[bkc_pkg::PIN_SDA];
    end
  end

  assign sda_f = pin_f_r[bkc_pkg::PIN_SDA];
  assign scl_rise = pin_f_r[bkc_pkg::PIN_SCL] && !scl_prev_r;
  assign scl_fall = !pin_f_r[bkc_pkg::PIN_SCL] && scl_prev_r;
  assign start_c = scl_prev_r && pin_f_r[bkc_pkg::PIN_SCL] && sda_prev_r && !sda_f;
  assign stop_c = scl_prev_r && pin_f_r[bkc_pkg::PIN_SCL] && !sda_prev_r && sda_f;

  // register read mux, unmapped offsets read as zero
  function automatic logic [7:0] rd_mux(input logic [7:0] a);
    logic [7:0] d;
    d = 8'h00;
    for (int i = 0; i < 4; i++) begin
      if (a == bkc_pkg::OFS_CTRL_BASE + 8'(i)) d = ctrl_r[i];
      if (a == bkc_pkg::OFS_REF_BASE + 8'(2 * i)) d = {2'b00, refa_r[i]};
      if (a == bkc_pkg::OFS_REF_BASE + 8'(2 * i + 1)) d = {2'b00, refb_r[i]};
    end
    if (a == bkc_pkg::OFS_STATUS) d = {soft_start_active, slewing};
    if (a == bkc_pkg::OFS_PG_STATUS) d = {4'h0, pin_f_r[bkc_pkg::PIN_PG +: 4]};
    return d;
  endfunction

  assign rd_data = rd_mux(ptr_r);

  // serial slave: first written byte is the pointer, then auto-increment
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= bkc_pkg::BKC_IDLE;
      sh_r <= 8'h00;
      tx_r <= 8'h00;
      ptr_r <= 8'h00;
      cnt_r <= 3'h0;
      done_r <= 1'b0;
      first_r <= 1'b0;
      rw_r <= 1'b0;
      sda_oen <= 1'b1;
      wr_stb_r <= 1'b0;
      wr_addr_r <= 8'h00;
      wr_data_r <= 8'h00;
    end else begin
      wr_stb_r <= 1'b0;
      if (start_c) begin
        st_r <= bkc_pkg::BKC_ADDR;
        cnt_r <= 3'h0;
        done_r <= 1'b0;
        first_r <= 1'b1;
        sda_oen <= 1'b1;
      end else if (stop_c) begin
        st_r <= bkc_pkg::BKC_IDLE;
        sda_oen <= 1'b1;
      end else begin
        unique case (st_r)
          bkc_pkg::BKC_IDLE: begin
            sda_oen <= 1'b1;
          end
          bkc_pkg::BKC_ADDR, bkc_pkg::BKC_WR: begin
            if (scl_rise) begin
              sh_r <= {sh_r[6:0], sda_f};
              cnt_r <= cnt_r + 3'h1;
              done_r <= (cnt_r == 3'h7);
            end else if (scl_fall && done_r) begin
              done_r <= 1'b0;
              if (st_r == bkc_pkg::BKC_ADDR) begin
                // foreign address: stay off the bus until the next start
                if (sh_r[7:1] == DEV_ADDR) begin
                  st_r <= bkc_pkg::BKC_ACK_A;
                  rw_r <= sh_r[0];
                  sda_oen <= 1'b0;
                end else begin
                  st_r <= bkc_pkg::BKC_IDLE;
                end
              end else begin
                st_r <= bkc_pkg::BKC_ACK_W;
                sda_oen <= 1'b0;
                first_r <= 1'b0;
                if (first_r) begin
                  ptr_r <= sh_r;
                end else begin
                  wr_stb_r <= 1'b1;
                  wr_addr_r <= ptr_r;
                  wr_data_r <= sh_r;
                  ptr_r <= ptr_r + 8'h01;
                end
              end
            end
          end
          bkc_pkg::BKC_ACK_A: begin
            if (scl_fall) begin
              cnt_r <= 3'h0;
              if (rw_r) begin
                st_r <= bkc_pkg::BKC_RD;
                tx_r <= rd_data;
                sda_oen <= rd_data[7];
                ptr_r <= ptr_r + 8'h01;
              end else begin
                st_r <= bkc_pkg::BKC_WR;
                sda_oen <= 1'b1;
              end
            end
          end
          bkc_pkg::BKC_ACK_W: begin
            if (scl_fall) begin
              st_r <= bkc_pkg::BKC_WR;
              sda_oen <= 1'b1;
              cnt_r <= 3'h0;
            end
          end
          bkc_pkg::BKC_RD: begin
            if (scl_rise) begin
              tx_r <= {tx_r[6:0], 1'b0};
              cnt_r <= cnt_r + 3'h1;
              done_r <= (cnt_r == 3'h7);
            end else if (scl_fall) begin
              if (done_r) begin
                done_r <= 1'b0;
                st_r <= bkc_pkg::BKC_ACK_R;
                sda_oen <= 1'b1;
              end else begin
                sda_oen <= tx_r[7];
              end
            end
          end
          bkc_pkg::BKC_ACK_R: begin
            // a nack from the master ends the read
            if (scl_rise && sda_f) begin
              st_r <= bkc_pkg::BKC_IDLE;
            end else if (scl_fall) begin
              st_r <= bkc_pkg::BKC_RD;
              cnt_r <= 3'h0;
              tx_r <= rd_data;
              sda_oen <= rd_data[7];
              ptr_r <= ptr_r + 8'h01;
            end
          end
          default: begin
            st_r <= bkc_pkg::BKC_IDLE;
            sda_oen <= 1'b1;
          end
        endcase
      end
    end
  end

  assign sda_o = 1'b0;

  // standby entry detect, sequencer is on this clock
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      standby_prev_r <= 1'b0;
    end else begin
      standby_prev_r <= standby_state;
    end
  end

  assign standby_entry = standby_state && !standby_prev_r;

  generate
    for (genvar i = 0; i < 4; i++) begin : g_reg
      logic [bkc_pkg::UV_W-1:0] dac_r;
      logic [bkc_pkg::UV_W-1:0] ss_r;
      logic [bkc_pkg::UV_W-1:0] target;
      logic [4:0] code_sel;
      logic on_r;
      logic on_req;
      logic [1:0] mode_sel;

      // register writes; standby entry clears the enable bit
      always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          ctrl_r[i] <= bkc_pkg::CTRL_RESET;
          refa_r[i] <= bkc_pkg::REF_RESET; // RL17
          refb_r[i] <= bkc_pkg::REF_RESET; // RL17
        end else begin
          if (wr_stb_r && wr_addr_r == bkc_pkg::OFS_CTRL_BASE + 8'(i)) ctrl_r[i] <= wr_data_r;
          if (wr_stb_r && wr_addr_r == bkc_pkg::OFS_REF_BASE + 8'(2 * i)) refa_r[i] <= wr_data_r[5:0];
          if (wr_stb_r && wr_addr_r == bkc_pkg::OFS_REF_BASE + 8'(2 * i + 1)) refb_r[i] <= wr_data_r[5:0];
          if (standby_entry) ctrl_r[i][bkc_pkg::CTRL_ENABLE] <= 1'b0; // RL18
        end
      end

      // pin ORed with the select bit, so a set bit leaves the pin inert
      assign code_sel = (refa_r[i][bkc_pkg::REF_FLAG] || pin_f_r[bkc_pkg::PIN_VSEL]) ? // RL12 RL13
                        refb_r[i][bkc_pkg::REF_CODE_MSB:0] : refa_r[i][bkc_pkg::REF_CODE_MSB:0];
      assign target = bkc_pkg::REF_BASE_UV + bkc_pkg::UV_W'(code_sel) * bkc_pkg::REF_STEP_UV; // RL10

      // in standby only keep-alive holds it; pins are ignored there
      assign on_req = standby_state ? ctrl_r[i][bkc_pkg::CTRL_KEEP_STBY] : // RL4 RL18
                      (ctrl_r[i][bkc_pkg::CTRL_ENABLE] || pin_f_r[bkc_pkg::PIN_EN + i]); // RL9

      // turn-on may wait for a discharged output; once on it stays on until the request drops
      always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          on_r <= 1'b0;
        end else if (!on_req) begin
          on_r <= 1'b0;
        end else if (!on_r) begin
          on_r <= !ctrl_r[i][bkc_pkg::CTRL_LOW_V_GATE] || pin_f_r[bkc_pkg::PIN_LOWV + i]; // RL7
        end
      end

      // dac moves a fixed step per cycle toward whatever is selected now
      always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          dac_r <= bkc_pkg::REF_BASE_UV + 20'(bkc_pkg::REF_RESET[4:0]) * bkc_pkg::REF_STEP_UV;
        end else if (dac_r < target) begin
          dac_r <= (target - dac_r > bkc_pkg::SLEW_STEP_UV) ? dac_r + bkc_pkg::SLEW_STEP_UV : target; // RL11 RL20
        end else if (dac_r > target) begin
          dac_r <= (dac_r - target > bkc_pkg::SLEW_STEP_UV) ? dac_r - bkc_pkg::SLEW_STEP_UV : target; // RL11 RL20
        end
      end

      assign slewing[i] = (dac_r != target);

      // soft-start ramp from ground; done once it meets the dac
      always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          ss_r <= '0;
          ss_done_r[i] <= 1'b0;
        end else if (!on_r) begin
          ss_r <= '0;
          ss_done_r[i] <= 1'b0;
        end else if (!ss_done_r[i]) begin
          if (dac_r - ss_r > bkc_pkg::SS_STEP_UV && ss_r < dac_r) begin
            ss_r <= ss_r + bkc_pkg::SS_STEP_UV; // RL1
          end else begin
            ss_r <= dac_r;
            ss_done_r[i] <= 1'b1;
          end
        end
      end

      // reserved mode code and soft-start both fall back to skipping
      assign mode_sel = (on_r && !ss_done_r[i]) ? bkc_pkg::MODE_PULSE_SKIP : // RL2
                        (ctrl_r[i][6:5] == 2'h3) ? bkc_pkg::MODE_PULSE_SKIP : ctrl_r[i][6:5]; // RL8 RL19

      // registered converter controls
      always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          reg_on[i] <= 1'b0;
          fast_edge[i] <= 1'b0;
          sw_freq_low[i] <= 1'b0;
          phase2_sel[i] <= 1'b0;
          op_mode[i] <= bkc_pkg::MODE_PULSE_SKIP;
          soft_start_active[i] <= 1'b0;
          ref_uv[i] <= '0;
        end else begin
          reg_on[i] <= on_r;
          fast_edge[i] <= ctrl_r[i][bkc_pkg::CTRL_FAST_EDGE]; // RL3
          sw_freq_low[i] <= ctrl_r[i][bkc_pkg::CTRL_FREQ_LOW] ^ ((i == 0) && DDR_VARIANT); // RL5
          phase2_sel[i] <= ctrl_r[i][bkc_pkg::CTRL_PHASE2]; // RL6
          op_mode[i] <= mode_sel;
          soft_start_active[i] <= on_r && !ss_done_r[i];
          ref_uv[i] <= !on_r ? '0 : (ss_done_r[i] ? dac_r : ss_r);
        end
      end
    end
  endgenerate

  // slew pulls the pin only; the status register keeps comparator state
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pg_pull_r <= 1'b1;
    end else begin
      pg_pull_r <= (pin_f_r[bkc_pkg::PIN_PG +: 4] != 4'hF) ||
                   ((slewing & ~{refb_r[3][5], refb_r[2][5], refb_r[1][5], refb_r[0][5]}) != 4'h0); // RL15 RL16
    end
  end

  assign power_good_o = 1'b0;
  assign power_good_oen = !pg_pull_r;

endmodule

// [bench/bkc_host_model.sv]
`timescale 1ns/1ps
// serial host, open-drain data, twelve clocks per third of a bit
module bkc_host_model (
  // clock
  input wire logic clk,
  // bus lines
  input wire logic sda_in,
  output logic scl,
  output logic sda_drv_n
);
  localparam logic [6:0] ADDR = 7'h3C; // arbitrary, same as device default
  // released bus at start
  initial begin
    scl = 1'b1;
    sda_drv_n = 1'b1;
  end
  task automatic hp;
    repeat (12) @(negedge clk);
  endtask
  // data only moves while the clock is low
  task automatic bit_io(input logic b, output logic r);
    sda_drv_n = b;
    hp();
    scl = 1'b1;
    hp();
    r = sda_in;
    scl = 1'b0;
    hp();
  endtask
  // also serves as repeated start
  task automatic start;
    sda_drv_n = 1'b1;
    hp();
    scl = 1'b1;
    hp();
    sda_drv_n = 1'b0;
    hp();
    scl = 1'b0;
    hp();
  endtask
  task automatic stop;
    sda_drv_n = 1'b0;
    hp();
    scl = 1'b1;
    hp();
    sda_drv_n = 1'b1;
    hp();
  endtask
  task automatic byte_io(input logic [7:0] tx, input logic ack_out, output logic [7:0] rx, output logic ack_in);
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(ack_out, ack_in);
  endtask
  task automatic wr(input logic [7:0] ptr, input logic [7:0] val, output logic nak);
    logic [7:0] rx;
    logic a0, a1, a2;
    start();
    byte_io({ADDR, 1'b0}, 1'b1, rx, a0);
    byte_io(ptr, 1'b1, rx, a1);
    byte_io(val, 1'b1, rx, a2);
    stop();
    nak = a0 | a1 | a2;
  endtask
  // single byte read, host refuses more data
  task automatic rd(input logic [7:0] ptr, output logic [7:0] val, output logic nak);
    logic [7:0] rx;
    logic a0, a1, a2, a3;
    start();
    byte_io({ADDR, 1'b0}, 1'b1, rx, a0);
    byte_io(ptr, 1'b1, rx, a1);
    start();
    byte_io({ADDR, 1'b1}, 1'b1, rx, a2);
    byte_io(8'hFF, 1'b1, val, a3);
    stop();
    nak = a0 | a1 | a2;
  endtask
endmodule

// [bench/bkc_monitor.sv]
`timescale 1ns/1ps
module bkc_monitor (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // watched ports
  input wire logic [3:0] reg_on,
  input wire logic [3:0] soft_start_active,
  input wire logic [3:0][1:0] op_mode,
  input wire logic [3:0][bkc_pkg::UV_W-1:0] ref_uv,
  input wire logic [3:0] pg_comparator_ok,
  input wire logic power_good_oen
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // per regulator reference and mode checks
  for (genvar i = 0; i < 4; i++) begin : g_reg
    property p_ss_start;
      $rose(reg_on[i]) |-> ##[0:2] soft_start_active[i];
    endproperty
    a_ss_start: assert property (p_ss_start) else $error("no soft start");
    property p_ss_ramp;
      soft_start_active[i] && $past(soft_start_active[i]) |-> ref_uv[i] - $past(ref_uv[i]) <= bkc_pkg::SS_STEP_UV;
    endproperty
    a_ss_ramp: assert property (p_ss_ramp) else $error("ramp too fast");
    property p_ss_mode;
      soft_start_active[i] |-> op_mode[i] == bkc_pkg::MODE_PULSE_SKIP;
    endproperty
    a_ss_mode: assert property (p_ss_mode) else $error("mode in soft start");
    property p_off_ref;
      !reg_on[i] [*3] |-> ref_uv[i] == '0;
    endproperty
    a_off_ref: assert property (p_off_ref) else $error("ref while off");
    property p_slew;
      reg_on[i] && $past(reg_on[i]) |-> (ref_uv[i] >= $past(ref_uv[i]) ? ref_uv[i] - $past(ref_uv[i])
        : $past(ref_uv[i]) - ref_uv[i]) <= bkc_pkg::SLEW_STEP_UV;
    endproperty
    a_slew: assert property (p_slew) else $error("ref step too big");
    property p_range;
      reg_on[i] && !soft_start_active[i] && $past(!soft_start_active[i]) && $past(reg_on[i], 2)
        |-> ref_uv[i] >= bkc_pkg::REF_BASE_UV && ref_uv[i] <= 20'hC3500;
    endproperty
    a_range: assert property (p_range) else $error("ref out of range");
    property p_mode_legal;
      op_mode[i] != 2'h3;
    endproperty
    a_mode_legal: assert property (p_mode_legal) else $error("reserved mode");
  end
  // a failing comparator must reach the pin after sync
  property p_pg_low;
    (!(&pg_comparator_ok)) [*8] |-> !power_good_oen;
  endproperty
  a_pg_low: assert property (p_pg_low) else $error("pg not low");
endmodule
bind bkc_top bkc_monitor u_mon (.ref_clk(ref_clk), .rstn(rstn), .reg_on(reg_on),
  .soft_start_active(soft_start_active), .op_mode(op_mode), .ref_uv(ref_uv),
  .pg_comparator_ok(pg_comparator_ok), .power_good_oen(power_good_oen));

// [bench/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  logic ref_clk, rstn, scl, host_sda_n, en2, vsel, stby, sda_oen, pg_oen, nak;
  logic [3:0] below, pg_ok, reg_on, fast_edge, sw_freq_low, phase2_sel, soft_start_active;
  logic [3:0][1:0] op_mode;
  logic [3:0][bkc_pkg::UV_W-1:0] ref_uv;
  logic [7:0] d;
  int n_mismatch, compares, cyc;
  // open drain with pull-up
  wire sda = host_sda_n & sda_oen;
  bkc_top u_dut (.ref_clk(ref_clk), .rstn(rstn), .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oen(sda_oen),
    .reg1_enable_pin(1'b0), .reg2_enable_pin(en2), .reg3_enable_pin(1'b0), .reg4_enable_pin(1'b0),
    .standby_voltage_select_pin(vsel), .out_below_300mv(below), .pg_comparator_ok(pg_ok),
    .standby_state(stby), .reg_on(reg_on), .fast_edge(fast_edge), .sw_freq_low(sw_freq_low),
    .phase2_sel(phase2_sel), .op_mode(op_mode), .soft_start_active(soft_start_active), .ref_uv(ref_uv),
    .power_good_o(), .power_good_oen(pg_oen));
  bkc_host_model u_host (.clk(ref_clk), .sda_in(sda), .scl(scl), .sda_drv_n(host_sda_n));
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] v);
    u_host.wr(p, v, nak);
    chk("ack", nak, 1'b0);
  endtask
  task automatic rd(input logic [7:0] p);
    u_host.rd(p, d, nak);
    chk("ack", nak, 1'b0);
  endtask
  task automatic test_done;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic t_defaults;
    rd(8'h00);
    chk("ctrl1", d, bkc_pkg::CTRL_RESET);
    rd(8'h05);
    chk("code b1", d, 8'h19);
    chk("cfg", {fast_edge, sw_freq_low, phase2_sel, reg_on}, 16'h0000);
    // a failing comparator pulls the pin and shows in status
    pg_ok = 4'hE;
    w(12);
    chk("pg fail", pg_oen, 1'b0);
    rd(8'h0D);
    chk("pg stat", d, 8'h0E);
    pg_ok = 4'hF;
    w(12);
    chk("pg ok", pg_oen, 1'b1);
  endtask
  task automatic t_fields;
    wr(8'h01, 8'h0D);
    w(4);
    chk("fast", fast_edge, 4'h2);
    chk("freq", sw_freq_low, 4'h2);
    chk("phase", phase2_sel, 4'h2);
    rd(8'h01);
    chk("ctrl2", d, 8'h0D);
    rd(8'h3A);
    chk("unmapped", d, 8'h00);
    wr(8'h01, 8'h00);
  endtask
  task automatic t_enable;
    en2 = 1'b1;
    w(12);
    chk("pin on", reg_on[1], 1'b1);
    en2 = 1'b0;
    w(12);
    chk("pin off", reg_on[1], 1'b0);
    wr(8'h02, 8'h90);
    w(8);
    chk("gated", reg_on[2], 1'b0);
    wr(8'h02, 8'h00);
    stby = 1'b1;
    wr(8'h03, 8'h02);
    w(8);
    chk("keep", reg_on[3], 1'b1);
    wr(8'h03, 8'h00);
    w(8);
    chk("drop", reg_on[3], 1'b0);
    stby = 1'b0;
  endtask
  task automatic t_ref;
    wr(8'h00, 8'hC0);
    w(8);
    chk("on", reg_on[0], 1'b1);
    chk("ss", soft_start_active[0], 1'b1);
    chk("ss mode", op_mode[0], 2'h0);
    for (int n = 0; n < 30000 && soft_start_active[0] !== 1'b0; n++) w(1);
    chk("ss end", ref_uv[0], 20'hB1008);
    chk("forced", op_mode[0], 2'h2);
    for (int m = 0; m < 4; m++) begin
      wr(8'h00, {1'b1, 2'(m), 5'h00});
      w(4);
      chk("mode", op_mode[0], (m == 3) ? 0 : m);
    end
    wr(8'h04, 8'h00);
    w(20);
    chk("pg slew", pg_oen, 1'b0);
    rd(8'h0D);
    chk("pg status", d, 8'h0F);
    for (int n = 0; n < 4000 && ref_uv[0] !== bkc_pkg::REF_BASE_UV; n++) w(1);
    chk("code 0", ref_uv[0], bkc_pkg::REF_BASE_UV);
    w(12);
    chk("pg back", pg_oen, 1'b1);
    vsel = 1'b1;
    w(200);
    wr(8'h05, 8'h3F);
    w(5);
    chk("no mask", pg_oen, 1'b1);
    for (int n = 0; n < 8000 && ref_uv[0] !== 20'hC3500; n++) w(1);
    chk("code 31", ref_uv[0], 20'hC3500);
    // A equal to B so the pin changes nothing
    wr(8'h04, 8'h1F);
    vsel = 1'b0;
    w(50);
    chk("held", ref_uv[0], 20'hC3500);
    stby = 1'b1;
    w(4);
    chk("stby off", reg_on[0], 1'b0);
    rd(8'h00);
    chk("bit7 clear", d, 8'h60);
    stby = 1'b0;
    w(8);
    chk("stays off", reg_on[0], 1'b0);
  endtask
  // free-running clock
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // hang guard, well above the expected run
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 90000) begin
      n_mismatch++;
      test_done();
    end
  end
  // main sequence
  initial begin
    rstn = 1'b0;
    {en2, vsel, stby} = 3'h0;
    below = 4'h0;
    pg_ok = 4'hF;
    w(3);
    rstn = 1'b1;
    w(8);
    t_defaults();
    t_fields();
    t_enable();
    t_ref();
    test_done();
  end
endmodule
